// ==== hdl/hrs_top.sv ====
// hard-reset sequencer: reset outputs, pin states during reset, register access rules
// Function
// R1 - hard reset starts on power-good loss or a software write to reset control.
// R2 - during hard reset PCI control, address/data, byte enables float; parity is input.
// R3 - during hard reset strobes high, latch/speaker/BALE low, data floats, ISA reset high.
// R4 - enable, DMA acknowledge, system clock, terminal count pins act as straps.
// R5 - every hard reset reloads all registers with their default values.
// R6 - accesses to reserved locations complete normally without hanging.
// R7 - software should not write reserved locations above offset 3Fh.
// R8 - software masks reserved bits on reads and merges them on writes.
// R9 - writes to read-only registers change nothing.
// R10 - reads of write-only registers return nothing meaningful, no side effect.
// R11 - read/write registers may hold bits that ignore writes.
// R12 - writing 1 clears a write-clear bit, writing 0 leaves it.
// R13 - PCI masters reach all registers, ISA masters only a subset.
// R14 - power-good low asserts CPU, PCI and ISA resets; release when high.
// R15 - software hard reset holds PCI reset for at least 1 ms.
`timescale 1ns/10ps
`default_nettype none
`include "hrs_cfg.svh"

module hrs_top
    import hrs_pkg::*;
#(
    parameter int unsigned SWRST_CYCLES = `HRS_SWRST_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic power_good_in_i,
    input wire logic acc_req_i,
    input wire logic acc_wr_i,
    input wire logic acc_isa_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic core_pci_ctl_oe_i,
    input wire logic core_pci_ad_oe_i,
    input wire logic core_pci_par_oe_i,
    input wire logic core_init_i,
    input wire logic [3:0] core_io_strobe_n_i,
    input wire logic core_ide_read_strobe_n_i,
    input wire logic core_ide_write_strobe_n_i,
    input wire logic [1:0] core_ide_dma_ack_n_i,
    input wire logic core_xbus_xcvr_dir_n_i,
    input wire logic core_xbus_xcvr_oe_n_i,
    input wire logic core_sd_buffer_oe_n_i,
    input wire logic core_sd_buffer_dir_i,
    input wire logic core_sd_oe_i,
    input wire logic core_bale_i,
    input wire logic core_speaker_i,
    input wire logic core_clock_chip_latch_i,
    input wire logic [2:0] core_chip_sel_n_i,
    input wire logic core_aen_i,
    input wire logic [6:0] core_dma_ack_n_i,
    input wire logic core_sysclk_i,
    input wire logic core_tc_i,
    input wire logic aen_i,
    input wire logic [6:0] dma_ack_n_i,
    input wire logic sysclk_i,
    input wire logic tc_i,
    output logic acc_done_o,
    output logic [7:0] acc_rdata_o,
    output logic cpu_hard_reset_out_o,
    output logic pci_bus_reset_n_o,
    output logic isa_reset_out_o,
    output logic cpu_init_o,
    output logic pci_ctl_oe_o,
    output logic pci_ad_oe_o,
    output logic pci_par_oe_o,
    output logic [3:0] io_strobe_n_o,
    output logic ide_read_strobe_n_o,
    output logic ide_write_strobe_n_o,
    output logic [1:0] ide_dma_ack_n_o,
    output logic xbus_xcvr_dir_n_o,
    output logic xbus_xcvr_oe_n_o,
    output logic sd_buffer_oe_n_o,
    output logic sd_buffer_dir_o,
    output logic sd_oe_o,
    output logic bale_o,
    output logic speaker_out_o,
    output logic clock_chip_addr_latch_o,
    output logic boot_rom_select_n_o,
    output logic keyboard_ctrl_select_n_o,
    output logic clock_chip_select_n_o,
    output logic aen_o,
    output logic aen_oe_o,
    output logic [6:0] dma_ack_n_o,
    output logic dma_ack_n_oe_o,
    output logic sysclk_o,
    output logic sysclk_oe_o,
    output logic tc_o,
    output logic tc_oe_o
);
    localparam logic [7:0][7:0] RO_TAB = `HRS_RO_MASKS;
    localparam logic [7:0][7:0] RWC_TAB = `HRS_RWC_MASKS;
    localparam logic [7:0] WO_SET = `HRS_WO_ENTRIES;
    localparam logic [7:0] ISA_SET = `HRS_ISA_ENTRIES;
    localparam logic [2:0] IDX_RC = 3'(`HRS_OFF_RC - `HRS_REG_BASE);
    localparam logic [2:0] IDX_STAT = 3'(`HRS_OFF_STAT - `HRS_REG_BASE);
    localparam logic [2:0] IDX_STRAP = 3'(`HRS_OFF_STRAP - `HRS_REG_BASE);
    localparam logic [2:0] IDX_DACK = 3'(`HRS_OFF_STRAP_DACK - `HRS_REG_BASE);
    localparam logic [2:0] IDX_RSVD = 3'(`HRS_OFF_RSVD - `HRS_REG_BASE);
    localparam logic [7:0] BASE = `HRS_REG_BASE;
    localparam logic [`HRS_CNT_W-1:0] CNT_LAST = `HRS_CNT_W'(SWRST_CYCLES - 1);

    hrs_state_t s_q;
    hrs_state_t s_d;
    hrs_rf_if rf ();

    logic [2:0] idx;
    logic in_range;
    logic isa_deny;
    logic rsvd;
    logic take;
    logic rc_hard;
    logic rc_soft;
    logic hard;
    logic release_now;
    logic [7:0][7:0] set_bits;

    hrs_regfile u_regs (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .rf(rf.mem)
    );

    assign idx = acc_addr_i[2:0];
    assign in_range = (acc_addr_i[7:3] == BASE[7:3]);
    assign isa_deny = acc_isa_i && !ISA_SET[idx]; // R13
    // out-of-map, reserved or refused accesses still complete with zero data
    assign rsvd = !in_range || (idx == IDX_RSVD) || isa_deny; // R6
    assign take = acc_req_i && !s_q.busy && (s_q.st == HRS_ST_RUN);

    assign rf.idx = idx;
    assign rf.we = take && acc_wr_i && !rsvd;
    assign rf.re = take && !acc_wr_i && !rsvd && !WO_SET[idx]; // R10
    assign rf.wmask = ~RO_TAB[idx] & ~RWC_TAB[idx]; // R9 R11
    assign rf.wdata = acc_wdata_i;
    assign rf.clr = acc_wdata_i & RWC_TAB[idx]; // R12
    assign rf.load_def = (s_q.st != HRS_ST_RUN); // R5
    assign rf.set_bits = set_bits;

    assign rc_hard = rf.we && (idx == IDX_RC) && acc_wdata_i[`HRS_RC_HARD];
    assign rc_soft = rf.we && (idx == IDX_RC) && acc_wdata_i[`HRS_RC_SOFT];

    always_comb begin
        s_d = s_q;
        set_bits = '0;
        case (s_q.st)
            HRS_ST_PWR: begin
                if (power_good_in_i) begin
                    s_d.st = HRS_ST_RUN; // R14
                end
            end
            HRS_ST_RUN: begin
                if (!power_good_in_i) begin
                    s_d.st = HRS_ST_PWR; // R1 R14
                end else if (rc_hard) begin
                    s_d.st = HRS_ST_SWRST; // R1
                    s_d.cnt = '0;
                end
            end
            HRS_ST_SWRST: begin
                if (!power_good_in_i) begin
                    s_d.st = HRS_ST_PWR;
                end else if (s_q.cnt == CNT_LAST) begin
                    s_d.st = HRS_ST_RUN; // R15
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            default: begin
                s_d.st = HRS_ST_PWR;
            end
        endcase
        hard = (s_d.st != HRS_ST_RUN);
        release_now = hard ? 1'b0 : (s_q.st != HRS_ST_RUN);

        // straps are sampled in the last cycle the pins are still floated
        if (release_now) begin
            set_bits[IDX_STRAP][`HRS_SP_AEN] = aen_i; // R4
            set_bits[IDX_STRAP][`HRS_SP_SYSCLK] = sysclk_i; // R4
            set_bits[IDX_STRAP][`HRS_SP_TC] = tc_i; // R4
            set_bits[IDX_DACK] = {1'b0, dma_ack_n_i}; // R4
        end
        set_bits[IDX_STAT][`HRS_ST_RSVD] = take && rsvd;
        set_bits[IDX_STAT][`HRS_ST_ISA] = take && isa_deny;

        // read data is registered at the taking edge, so done follows one edge later
        s_d.acc_done = s_q.busy;
        s_d.acc_rdata = (s_q.busy && s_q.p_rd) ? rf.rdata : 8'h00;
        s_d.busy = take;
        s_d.p_rd = rf.re;

        // pins follow the core one cycle late while the part runs
        s_d.cpu_hard_reset = hard; // R14
        s_d.pci_bus_reset_n = !hard; // R14 R15
        s_d.isa_reset_out = hard; // R3 R14
        s_d.cpu_init = core_init_i || rc_soft;
        s_d.pci_ctl_oe = core_pci_ctl_oe_i;
        s_d.pci_ad_oe = core_pci_ad_oe_i;
        s_d.pci_par_oe = core_pci_par_oe_i;
        s_d.io_strobe_n = core_io_strobe_n_i;
        s_d.ide_read_strobe_n = core_ide_read_strobe_n_i;
        s_d.ide_write_strobe_n = core_ide_write_strobe_n_i;
        s_d.ide_dma_ack_n = core_ide_dma_ack_n_i;
        s_d.xbus_xcvr_dir_n = core_xbus_xcvr_dir_n_i;
        s_d.xbus_xcvr_oe_n = core_xbus_xcvr_oe_n_i;
        s_d.sd_buffer_oe_n = core_sd_buffer_oe_n_i;
        s_d.sd_buffer_dir = core_sd_buffer_dir_i;
        s_d.sd_oe = core_sd_oe_i;
        s_d.bale = core_bale_i;
        s_d.speaker_out = core_speaker_i;
        s_d.clock_chip_addr_latch = core_clock_chip_latch_i;
        s_d.chip_sel_n = core_chip_sel_n_i;
        s_d.aen = core_aen_i;
        s_d.aen_oe = 1'b1;
        s_d.dma_ack_n = core_dma_ack_n_i;
        s_d.dma_ack_n_oe = 1'b1;
        s_d.sysclk = core_sysclk_i;
        s_d.sysclk_oe = 1'b1;
        s_d.tc = core_tc_i;
        s_d.tc_oe = 1'b1;

        // hard reset forces every non-strap pin to its fixed reset level; strap pins keep core values with enables off
        if (hard) begin
            s_d.cpu_init = 1'b0; // R3
            s_d.pci_ctl_oe = 1'b0; // R2
            s_d.pci_ad_oe = 1'b0; // R2
            s_d.pci_par_oe = 1'b0; // R2
            s_d.io_strobe_n = 4'hf; // R3
            s_d.ide_read_strobe_n = 1'b1; // R3
            s_d.ide_write_strobe_n = 1'b1; // R3
            s_d.ide_dma_ack_n = 2'h3; // R3
            s_d.xbus_xcvr_dir_n = 1'b1; // R3
            s_d.xbus_xcvr_oe_n = 1'b1; // R3
            s_d.sd_buffer_oe_n = 1'b1; // R3
            s_d.sd_buffer_dir = 1'b1; // R3
            s_d.sd_oe = 1'b0; // R3
            s_d.bale = 1'b0; // R3
            s_d.speaker_out = 1'b0; // R3
            s_d.clock_chip_addr_latch = 1'b0; // R3
            s_d.chip_sel_n = 3'h7;
            s_d.aen_oe = 1'b0; // R4
            s_d.dma_ack_n_oe = 1'b0; // R4
            s_d.sysclk_oe = 1'b0; // R4
            s_d.tc_oe = 1'b0; // R4
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.st <= HRS_ST_PWR;
            s_q.cpu_hard_reset <= 1'b1;
            s_q.isa_reset_out <= 1'b1;
            s_q.io_strobe_n <= 4'hf;
            s_q.ide_read_strobe_n <= 1'b1;
            s_q.ide_write_strobe_n <= 1'b1;
            s_q.ide_dma_ack_n <= 2'h3;
            s_q.xbus_xcvr_dir_n <= 1'b1;
            s_q.xbus_xcvr_oe_n <= 1'b1;
            s_q.sd_buffer_oe_n <= 1'b1;
            s_q.sd_buffer_dir <= 1'b1;
            s_q.chip_sel_n <= 3'h7;
        end else begin
            s_q <= s_d;
        end
    end

    assign acc_done_o = s_q.acc_done;
    assign acc_rdata_o = s_q.acc_rdata;
    assign cpu_hard_reset_out_o = s_q.cpu_hard_reset;
    assign pci_bus_reset_n_o = s_q.pci_bus_reset_n;
    assign isa_reset_out_o = s_q.isa_reset_out;
    assign cpu_init_o = s_q.cpu_init;
    assign pci_ctl_oe_o = s_q.pci_ctl_oe;
    assign pci_ad_oe_o = s_q.pci_ad_oe;
    assign pci_par_oe_o = s_q.pci_par_oe;
    assign io_strobe_n_o = s_q.io_strobe_n;
    assign ide_read_strobe_n_o = s_q.ide_read_strobe_n;
    assign ide_write_strobe_n_o = s_q.ide_write_strobe_n;
    assign ide_dma_ack_n_o = s_q.ide_dma_ack_n;
    assign xbus_xcvr_dir_n_o = s_q.xbus_xcvr_dir_n;
    assign xbus_xcvr_oe_n_o = s_q.xbus_xcvr_oe_n;
    assign sd_buffer_oe_n_o = s_q.sd_buffer_oe_n;
    assign sd_buffer_dir_o = s_q.sd_buffer_dir;
    assign sd_oe_o = s_q.sd_oe;
    assign bale_o = s_q.bale;
    assign speaker_out_o = s_q.speaker_out;
    assign clock_chip_addr_latch_o = s_q.clock_chip_addr_latch;
    assign boot_rom_select_n_o = s_q.chip_sel_n[0];
    assign keyboard_ctrl_select_n_o = s_q.chip_sel_n[1];
    assign clock_chip_select_n_o = s_q.chip_sel_n[2];
    assign aen_o = s_q.aen;
    assign aen_oe_o = s_q.aen_oe;
    assign dma_ack_n_o = s_q.dma_ack_n;
    assign dma_ack_n_oe_o = s_q.dma_ack_n_oe;
    assign sysclk_o = s_q.sysclk;
    assign sysclk_oe_o = s_q.sysclk_oe;
    assign tc_o = s_q.tc;
    assign tc_oe_o = s_q.tc_oe;
endmodule
`default_nettype wire

// ==== hdl/hrs_cfg.svh ====
// constants of the hard-reset sequencer and its register set
`ifndef HRS_CFG_SVH
`define HRS_CFG_SVH

`define HRS_CLK_MHZ 100
`define HRS_SWRST_MS 1
`define HRS_SWRST_CYCLES (`HRS_SWRST_MS * 1000 * `HRS_CLK_MHZ)
`define HRS_CNT_W 20

`define HRS_REG_BASE 8'h40
`define HRS_OFF_RC 8'h40
`define HRS_OFF_ID 8'h41
`define HRS_OFF_STAT 8'h42
`define HRS_OFF_SCR 8'h43
`define HRS_OFF_WO 8'h44
`define HRS_OFF_STRAP 8'h45
`define HRS_OFF_STRAP_DACK 8'h46
`define HRS_OFF_RSVD 8'h47

`define HRS_RC_HARD 0
`define HRS_RC_SOFT 1
`define HRS_ST_RSVD 0
`define HRS_ST_ISA 1
`define HRS_SP_AEN 0
`define HRS_SP_SYSCLK 1
`define HRS_SP_TC 2

// one byte per entry, entry 0 in the low byte; entry 1 default is arbitrary
`define HRS_DEF_VALS 64'h0000_0000_0000_5a00
`define HRS_RO_MASKS 64'hffff_ff00_f0fc_fffc
`define HRS_RWC_MASKS 64'h0000_0000_0003_0000
`define HRS_WO_ENTRIES 8'h10
`define HRS_ISA_ENTRIES 8'h09

`endif

// ==== hdl/hrs_pkg.sv ====
// types of the hard-reset sequencer
`default_nettype none
package hrs_pkg;
`include "hrs_cfg.svh"

    typedef enum logic [1:0] {
        HRS_ST_PWR = 2'b00,
        HRS_ST_RUN = 2'b01,
        HRS_ST_SWRST = 2'b10
    } hrs_st_t;

    typedef struct packed {
        logic [7:0][7:0] regs;
        logic [7:0] rdata;
    } hrs_rf_state_t;

    typedef struct packed {
        hrs_st_t st;
        logic [`HRS_CNT_W-1:0] cnt;
        logic busy;
        logic p_rd;
        logic acc_done;
        logic [7:0] acc_rdata;
        logic cpu_hard_reset;
        logic pci_bus_reset_n;
        logic isa_reset_out;
        logic cpu_init;
        logic pci_ctl_oe;
        logic pci_ad_oe;
        logic pci_par_oe;
        logic [3:0] io_strobe_n;
        logic ide_read_strobe_n;
        logic ide_write_strobe_n;
        logic [1:0] ide_dma_ack_n;
        logic xbus_xcvr_dir_n;
        logic xbus_xcvr_oe_n;
        logic sd_buffer_oe_n;
        logic sd_buffer_dir;
        logic sd_oe;
        logic bale;
        logic speaker_out;
        logic clock_chip_addr_latch;
        logic [2:0] chip_sel_n;
        logic aen;
        logic aen_oe;
        logic [6:0] dma_ack_n;
        logic dma_ack_n_oe;
        logic sysclk;
        logic sysclk_oe;
        logic tc;
        logic tc_oe;
    } hrs_state_t;
endpackage
`default_nettype wire

// ==== hdl/hrs_rf_if.sv ====
// link between the sequencer and its register storage
`timescale 1ns/10ps
`default_nettype none
interface hrs_rf_if;
    logic load_def;
    logic we;
    logic re;
    logic [2:0] idx;
    logic [7:0] wmask;
    logic [7:0] wdata;
    logic [7:0] clr;
    logic [7:0][7:0] set_bits;
    logic [7:0] rdata;

    modport ctrl (
        output load_def, we, re, idx, wmask, wdata, clr, set_bits,
        input rdata
    );
    modport mem (
        input load_def, we, re, idx, wmask, wdata, clr, set_bits,
        output rdata
    );
endinterface
`default_nettype wire

// ==== hdl/hrs_regfile.sv ====
// eight-byte register storage with masked write, write-one-clear and hardware set
`timescale 1ns/10ps
`default_nettype none
`include "hrs_cfg.svh"
module hrs_regfile
    import hrs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    hrs_rf_if.mem rf
);
    localparam logic [7:0][7:0] DEF_TAB = `HRS_DEF_VALS;

    hrs_rf_state_t s_q;
    hrs_rf_state_t s_d;
    wire logic [7:0][7:0] nxt;

    for (genvar i = 0; i < 8; i++) begin : g_ent
        wire logic hit = (rf.idx == 3'(i));
        wire logic [7:0] m = (rf.we && hit) ? rf.wmask : 8'h00;
        wire logic [7:0] c = (rf.we && hit) ? rf.clr : 8'h00;
        // hardware set wins over clear and over the default load
        assign nxt[i] = (rf.load_def ? DEF_TAB[i] :
                         ((((s_q.regs[i] & ~m) | (rf.wdata & m)) & ~c))) | rf.set_bits[i]; // R5 R11 R12
    end

    always_comb begin
        s_d = s_q;
        s_d.regs = nxt;
        if (rf.re) begin
            s_d.rdata = s_q.regs[rf.idx];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_q.regs <= DEF_TAB; // R5
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign rf.rdata = s_q.rdata;
endmodule
`default_nettype wire

// ==== bench/hrs_strap_model.sv ====
// far-side model: strap resistors on the pins the device floats in reset
`timescale 1ns/10ps
`default_nettype none
module hrs_strap_model (
    input wire logic [9:0] strap_i,
    input wire logic [9:0] drv_i,
    input wire logic [3:0] oe_i,
    output logic [9:0] wire_o
);
    // a released pin settles to its strap level, never to the last driven value
    assign wire_o = {oe_i[3] ? drv_i[9] : strap_i[9],
        oe_i[2] ? drv_i[8:2] : strap_i[8:2],
        oe_i[1] ? drv_i[1] : strap_i[1],
        oe_i[0] ? drv_i[0] : strap_i[0]};
endmodule
`default_nettype wire

// ==== bench/hrs_top_checker.sv ====
// assertions on the ports of the hard-reset sequencer
`timescale 1ns/10ps
`default_nettype none
module hrs_top_checker #(
    parameter int unsigned SWRST_CYCLES = 100000
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic power_good_in_i,
    input wire logic acc_req_i,
    input wire logic acc_wr_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_done_o,
    input wire logic [7:0] acc_rdata_o,
    input wire logic cpu_hard_reset_out_o,
    input wire logic pci_bus_reset_n_o,
    input wire logic isa_reset_out_o,
    input wire logic cpu_init_o,
    input wire logic pci_ctl_oe_o,
    input wire logic pci_ad_oe_o,
    input wire logic pci_par_oe_o,
    input wire logic [3:0] io_strobe_n_o,
    input wire logic ide_read_strobe_n_o,
    input wire logic ide_write_strobe_n_o,
    input wire logic [1:0] ide_dma_ack_n_o,
    input wire logic bale_o,
    input wire logic speaker_out_o,
    input wire logic clock_chip_addr_latch_o,
    input wire logic sd_oe_o,
    input wire logic aen_oe_o,
    input wire logic dma_ack_n_oe_o,
    input wire logic sysclk_oe_o,
    input wire logic tc_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic run;
    logic sw_hit;
    logic sw_q;
    int unsigned low_q;
    assign run = !cpu_hard_reset_out_o;
    assign sw_hit = acc_req_i && acc_wr_i && acc_addr_i == 8'h40 && acc_wdata_i[0] && run;
    // length of the current pci reset pulse and whether software started it
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || pci_bus_reset_n_o) begin
            low_q <= 0;
        end else begin
            low_q <= low_q + 1;
        end
        if (sys_rst_i || $rose(pci_bus_reset_n_o)) begin
            sw_q <= 1'b0;
        end else if (sw_hit) begin
            sw_q <= 1'b1;
        end
    end
    sequence s_take;
        $rose(acc_req_i) && run;
    endsequence
    sequence s_sw;
        s_take ##0 sw_hit;
    endsequence
    AST_PG_LOSS: assert property (!power_good_in_i |=> cpu_hard_reset_out_o && !pci_bus_reset_n_o && isa_reset_out_o) else $error("resets not asserted on power loss");
    AST_PG_REL: assert property ($rose(power_good_in_i) |=> run) else $error("resets not released on power good");
    AST_RST_TIED: assert property (cpu_hard_reset_out_o == isa_reset_out_o && cpu_hard_reset_out_o != pci_bus_reset_n_o) else $error("reset outputs disagree");
    AST_PCI_FLOAT: assert property (cpu_hard_reset_out_o |-> !(pci_ctl_oe_o || pci_ad_oe_o || pci_par_oe_o)) else $error("pci lines driven in reset");
    AST_ISA_IDLE: assert property (cpu_hard_reset_out_o |-> io_strobe_n_o == 4'hf && ide_read_strobe_n_o && ide_write_strobe_n_o && ide_dma_ack_n_o == 2'h3 && !bale_o && !speaker_out_o && !clock_chip_addr_latch_o && !sd_oe_o && !cpu_init_o) else $error("isa side not idle in reset");
    AST_STRAP_FLOAT: assert property (cpu_hard_reset_out_o |-> !(aen_oe_o || dma_ack_n_oe_o || sysclk_oe_o || tc_oe_o)) else $error("strap pin driven in reset");
    AST_DONE_LAT: assert property (s_take ##0 !sw_hit |=> !acc_done_o ##1 acc_done_o) else $error("access not completed after two cycles");
    AST_DONE_PULSE: assert property (acc_done_o |=> !acc_done_o) else $error("done longer than one cycle");
    AST_WO_READ: assert property (s_take ##0 (!acc_wr_i && acc_addr_i == 8'h44) |-> ##2 acc_rdata_o == 8'h00) else $error("write-only read returned data");
    AST_SW_START: assert property (s_sw |=> cpu_hard_reset_out_o && !pci_bus_reset_n_o) else $error("software reset did not start");
    AST_SW_HOLD: assert property ($rose(pci_bus_reset_n_o) && sw_q |-> low_q >= SWRST_CYCLES) else $error("software pci reset too short");
endmodule
bind hrs_top hrs_top_checker #(.SWRST_CYCLES(SWRST_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== bench/hrs_top_bench.sv ====
// self-checking bench of the hard-reset sequencer
`timescale 1ns/10ps
`default_nettype none
module hrs_top_bench;
    import hrs_pkg::*;
    localparam int unsigned SWN = 20;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic power_good_in_i = 1'b0;
    logic acc_req_i = 1'b0;
    logic acc_wr_i = 1'b0;
    logic acc_isa_i = 1'b0;
    logic [7:0] acc_addr_i = 8'h00;
    logic [7:0] acc_wdata_i = 8'h00;
    logic [32:0] cv = {23'h780079, 10'h2a5};
    logic [9:0] strap_v = 10'h15a;
    logic [9:0] sw;
    logic [7:0] acc_rdata_o, q;
    logic [3:0] io_strobe_n_o;
    logic [1:0] ide_dma_ack_n_o;
    logic [6:0] dma_ack_n_o;
    logic acc_done_o, cpu_hard_reset_out_o, pci_bus_reset_n_o, isa_reset_out_o, cpu_init_o;
    logic pci_ctl_oe_o, pci_ad_oe_o, pci_par_oe_o, ide_read_strobe_n_o, ide_write_strobe_n_o;
    logic xbus_xcvr_dir_n_o, xbus_xcvr_oe_n_o, sd_buffer_oe_n_o, sd_buffer_dir_o, sd_oe_o;
    logic bale_o, speaker_out_o, clock_chip_addr_latch_o, boot_rom_select_n_o;
    logic keyboard_ctrl_select_n_o, clock_chip_select_n_o, aen_o, aen_oe_o, dma_ack_n_oe_o;
    logic sysclk_o, sysclk_oe_o, tc_o, tc_oe_o;
    int fail_count = 0;
    int n_compared = 0;
    always #5 core_clk_i = ~core_clk_i;
    hrs_top #(.SWRST_CYCLES(SWN)) dut (
        .*,
        .core_pci_ctl_oe_i(cv[32]),
        .core_pci_ad_oe_i(cv[31]),
        .core_pci_par_oe_i(cv[30]),
        .core_init_i(cv[29]),
        .core_io_strobe_n_i(cv[28:25]),
        .core_ide_read_strobe_n_i(cv[24]),
        .core_ide_write_strobe_n_i(cv[23]),
        .core_ide_dma_ack_n_i(cv[22:21]),
        .core_xbus_xcvr_dir_n_i(cv[20]),
        .core_xbus_xcvr_oe_n_i(cv[19]),
        .core_sd_buffer_oe_n_i(cv[18]),
        .core_sd_buffer_dir_i(cv[17]),
        .core_sd_oe_i(cv[16]),
        .core_bale_i(cv[15]),
        .core_speaker_i(cv[14]),
        .core_clock_chip_latch_i(cv[13]),
        .core_chip_sel_n_i(cv[12:10]),
        .core_aen_i(cv[9]),
        .core_dma_ack_n_i(cv[8:2]),
        .core_sysclk_i(cv[1]),
        .core_tc_i(cv[0]),
        .aen_i(sw[9]),
        .dma_ack_n_i(sw[8:2]),
        .sysclk_i(sw[1]),
        .tc_i(sw[0])
    );
    hrs_strap_model u_strap (
        .strap_i(strap_v),
        .drv_i({aen_o, dma_ack_n_o, sysclk_o, tc_o}),
        .oe_i({aen_oe_o, dma_ack_n_oe_o, sysclk_oe_o, tc_oe_o}),
        .wire_o(sw)
    );
    function automatic logic [32:0] pins();
        return {pci_ctl_oe_o, pci_ad_oe_o, pci_par_oe_o, cpu_init_o, io_strobe_n_o,
            ide_read_strobe_n_o, ide_write_strobe_n_o, ide_dma_ack_n_o, xbus_xcvr_dir_n_o,
            xbus_xcvr_oe_n_o, sd_buffer_oe_n_o, sd_buffer_dir_o, sd_oe_o, bale_o,
            speaker_out_o, clock_chip_addr_latch_o, clock_chip_select_n_o,
            keyboard_ctrl_select_n_o, boot_rom_select_n_o, aen_o, dma_ack_n_o, sysclk_o,
            tc_o};
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic req(input logic wr, input logic isa, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        acc_req_i = 1'b1;
        acc_wr_i = wr;
        acc_isa_i = isa;
        acc_addr_i = a;
        acc_wdata_i = d;
        @(negedge core_clk_i);
        acc_req_i = 1'b0;
    endtask
    task automatic acc(input logic wr, input logic isa, input logic [7:0] a, input logic [7:0] d);
        req(wr, isa, a, d);
        @(posedge core_clk_i);
        #1;
        chk(acc_done_o, 1'b1);
        q = acc_rdata_o;
    endtask
    task automatic rd(input logic isa, input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, isa, a, 8'h00);
        chk(q, e);
    endtask
    task automatic t_power();
        chk(pins(), {23'h07ff87, cv[9:0]});
        chk({cpu_hard_reset_out_o, pci_bus_reset_n_o, isa_reset_out_o}, 3'h5);
        chk({pci_ctl_oe_o, pci_ad_oe_o, pci_par_oe_o}, 3'h0);
        chk({aen_oe_o, dma_ack_n_oe_o, sysclk_oe_o, tc_oe_o}, 4'h0);
        @(negedge core_clk_i);
        power_good_in_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        chk({cpu_hard_reset_out_o, pci_bus_reset_n_o, isa_reset_out_o}, 3'h2);
        chk(pins(), cv);
        chk({aen_oe_o, dma_ack_n_oe_o, sysclk_oe_o, tc_oe_o}, 4'hf);
        rd(1'b0, 8'h45, {5'h00, strap_v[0], strap_v[1], strap_v[9]});
        rd(1'b0, 8'h46, {1'b0, strap_v[8:2]});
        rd(1'b0, 8'h41, 8'h5a);
    endtask
    task automatic t_regs();
        acc(1'b1, 1'b0, 8'h41, 8'hff);
        rd(1'b0, 8'h41, 8'h5a);
        acc(1'b1, 1'b0, 8'h43, 8'hff);
        rd(1'b0, 8'h43, 8'h0f);
        rd(1'b1, 8'h43, 8'h0f);
        acc(1'b1, 1'b1, 8'h43, {q[7:4], 4'h5});
        rd(1'b0, 8'h43, 8'h05);
        rd(1'b0, 8'h44, 8'h00);
        rd(1'b0, 8'h42, 8'h00);
        acc(1'b1, 1'b0, 8'h30, 8'h77);
        rd(1'b0, 8'h47, 8'h00);
        rd(1'b1, 8'h41, 8'h00);
        rd(1'b0, 8'h42, 8'h03);
        acc(1'b1, 1'b0, 8'h42, 8'h00);
        rd(1'b0, 8'h42, 8'h03);
        acc(1'b1, 1'b0, 8'h42, 8'h02);
        rd(1'b0, 8'h42, 8'h01);
        @(negedge core_clk_i);
        cv[29] = 1'b0;
        req(1'b1, 1'b0, 8'h40, 8'h02);
        chk(cpu_init_o, 1'b1);
        @(posedge core_clk_i);
        #1;
        chk({acc_done_o, cpu_init_o}, 2'h2);
        @(negedge core_clk_i);
        cv[29] = 1'b1;
    endtask
    task automatic t_swrst();
        int n;
        acc(1'b1, 1'b0, 8'h43, 8'h0a);
        req(1'b1, 1'b0, 8'h40, 8'h01);
        chk({cpu_hard_reset_out_o, pci_bus_reset_n_o, isa_reset_out_o}, 3'h5);
        n = 0;
        while (pci_bus_reset_n_o !== 1'b1 && n < SWN + 10) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk(n >= SWN && n <= SWN + 2, 1'b1);
        rd(1'b0, 8'h43, 8'h00);
        rd(1'b0, 8'h42, 8'h00);
    endtask
    task automatic t_pgloss();
        acc(1'b1, 1'b0, 8'h43, 8'h06);
        @(negedge core_clk_i);
        power_good_in_i = 1'b0;
        strap_v = 10'h0f3;
        @(posedge core_clk_i);
        #1;
        chk({cpu_hard_reset_out_o, pci_bus_reset_n_o, isa_reset_out_o}, 3'h5);
        chk(pins(), {23'h07ff87, cv[9:0]});
        @(negedge core_clk_i);
        power_good_in_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        chk({cpu_hard_reset_out_o, pci_bus_reset_n_o, isa_reset_out_o}, 3'h2);
        rd(1'b0, 8'h43, 8'h00);
        rd(1'b0, 8'h46, {1'b0, strap_v[8:2]});
    endtask
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        t_power();
        t_regs();
        t_swrst();
        t_pgloss();
        stop_test();
    end
endmodule
`default_nettype wire
